// *** src/pwm_pkg.sv ***
/*
  Shared constants and types for the single channel pulse width modulator.
  Assumes a 32-bit APB master and a single system clock.
*/
package pwm_pkg;

  // Counter geometry.
  localparam int unsigned CNT_W      = 10;
  localparam int unsigned PRESC_W    = 3;
  localparam int unsigned SEL_W      = 2;

  // Register byte addresses.
  localparam logic [7:0] OFS_PERIOD_LOW   = 8'h00;
  localparam logic [7:0] OFS_PERIOD_HIGH  = 8'h04;
  localparam logic [7:0] OFS_COMPARE_LOW  = 8'h08;
  localparam logic [7:0] OFS_COMPARE_HIGH = 8'h0C;
  localparam logic [7:0] OFS_CONTROL      = 8'h10;
  localparam logic [7:0] OFS_CONTROL_3    = 8'h14;
  localparam logic [7:0] OFS_STATUS       = 8'h18;
  localparam logic [7:0] OFS_MASK         = 8'h1C;
  localparam logic [7:0] OFS_STATE        = 8'h20;

  // Field positions.
  localparam int unsigned BIT_RUN        = 0;
  localparam int unsigned BIT_LOAD       = 1;
  localparam int unsigned BIT_UNDERFLOW  = 0;
  localparam int unsigned BIT_STATE_OUT  = 16;
  localparam int unsigned HIGH_BYTE_W    = CNT_W - 8;

  // Reset values and special compare codes.
  localparam logic [CNT_W-1:0] CNT_ZERO     = 10'h000;
  localparam logic [CNT_W-1:0] CMP_ALL_ONES = 10'h3FF;
  localparam logic [CNT_W-1:0] PERIOD_RST   = 10'h000;
  localparam logic [CNT_W-1:0] COMPARE_RST  = 10'h000;
  localparam logic [SEL_W-1:0] SEL_RST      = 2'h0;
  localparam logic [PRESC_W-1:0] PRESC_ONE  = 3'h1;

  // A period and compare pair moves as one unit between holding and active.
  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] compare;
  } mod_values_t;

  // Bus access phase summary.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;

endpackage

// *** src/pwm_channel.sv ***
/*
  Single channel pulse width modulator with an APB register slave.
  Assumes a synchronous APB master on clk, a synchronous active high reset,
  and a port latch outside that passes the modulator output to the pin.
*/
// The implementer's own choices: the register addresses and register access over APB.
// Behaviour
// [R01] Internal output is high after reset.
// [R02] Software sets port latch before pin follows.
// [R03] Ten-bit down counter on prescaled clock.
// [R04] Prescale select in control three bits 1:0.
// [R05] Underflow reloads counter with active period.
// [R06] Repetition rate is counter clock over period+1.
// [R07] Underflow drives high; compare match drives low.
// [R08] High time is period minus compare plus one.
// [R09] Compare all zeroes holds output high.
// [R10] Compare all ones holds output low.
// [R11] Compare above period holds output low.
// [R12] Compare writes land in a holding register.
// [R13] Period writes land in a holding register.
// [R14] Clearing run freezes the output level.
// [R15] Software stops via constant code, load, wait.
// [R16] Load copies holding at underflow, self clears.
// [R17] Underflow sets sticky flag and raises interrupt.
// [R18] Prescale codes divide by 1, 2, 4, 8.
`timescale 1ns/1ps
module pwm_channel
  import pwm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Modulator output towards the port latch
  output logic             modulator_channel_zero,
  // Interrupt
  output logic             period_irq
);

  // Bus decode.
  bus_req_t   req;
  logic       access;
  logic       hit_pl;
  logic       hit_ph;
  logic       hit_cl;
  logic       hit_ch;
  logic       hit_ctl;
  logic       hit_ctl3;
  logic       hit_sts;
  logic       hit_msk;
  logic       hit_state;
  logic       mapped;
  logic [31:0] rd_mux;

  // Register state.
  mod_values_t            hold_q;
  mod_values_t            active_q;
  logic                   run_q;
  logic                   load_q;
  logic [SEL_W-1:0]       prescale_select_q;
  logic                   counter_underflow_flag_q;
  logic                   mask_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic [31:0]            prdata_q;
  logic                   irq_q;

  // Counter state.
  logic [PRESC_W-1:0]     presc_q;
  logic [PRESC_W-1:0]     presc_limit;
  logic                   tick;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cnt_d;
  logic                   out_q;
  logic                   out_d;
  logic                   underflow;
  logic                   force_high;
  logic                   force_low;
  logic                   match;

  assign req.wr    = psel & penable & pready_q & pwrite;
  assign req.rd    = psel & penable & ~pready_q & ~pwrite;
  assign req.addr  = paddr;
  assign req.wdata = pwdata;
  assign access    = psel & penable & ~pready_q;

  assign hit_pl    = (req.addr == OFS_PERIOD_LOW);
  assign hit_ph    = (req.addr == OFS_PERIOD_HIGH);
  assign hit_cl    = (req.addr == OFS_COMPARE_LOW);
  assign hit_ch    = (req.addr == OFS_COMPARE_HIGH);
  assign hit_ctl   = (req.addr == OFS_CONTROL);
  assign hit_ctl3  = (req.addr == OFS_CONTROL_3);
  assign hit_sts   = (req.addr == OFS_STATUS);
  assign hit_msk   = (req.addr == OFS_MASK);
  assign hit_state = (req.addr == OFS_STATE);
  assign mapped    = hit_pl | hit_ph | hit_cl | hit_ch | hit_ctl | hit_ctl3 |
                     hit_sts | hit_msk | hit_state;

  // Reads of the period and compare bytes return the holding copies. [R12] [R13]
  assign rd_mux =
    hit_pl    ? {24'h000000, hold_q.period[7:0]} :
    hit_ph    ? {30'h00000000, hold_q.period[CNT_W-1:8]} :
    hit_cl    ? {24'h000000, hold_q.compare[7:0]} :
    hit_ch    ? {30'h00000000, hold_q.compare[CNT_W-1:8]} :
    hit_ctl   ? {30'h00000000, load_q, run_q} :
    hit_ctl3  ? {30'h00000000, prescale_select_q} :
    hit_sts   ? {31'h00000000, counter_underflow_flag_q} :
    hit_msk   ? {31'h00000000, mask_q} :
    hit_state ? {15'h0000, out_q, 6'h00, cnt_q} :
                32'h00000000;

  // Divide ratio is two to the power of the select code. [R04] [R18]
  assign presc_limit = PRESC_W'((PRESC_ONE << prescale_select_q) - PRESC_ONE);
  assign tick        = run_q & (presc_q == presc_limit);
  assign underflow   = tick & (cnt_q == CNT_ZERO);

  // Special compare codes override the counter. [R09] [R10] [R11]
  assign force_high = (active_q.compare == COMPARE_RST);
  assign force_low  = (active_q.compare == CMP_ALL_ONES) |
                      (active_q.compare > active_q.period);
  assign match      = tick & (cnt_q == active_q.compare);

  // Down count with reload on underflow. [R03] [R05] [R06]
  assign cnt_d = underflow ? active_q.period :
                 tick      ? CNT_W'(cnt_q - 10'h001) :
                             cnt_q;

  // High from underflow to compare match, so high spans period-compare+1 ticks. [R07] [R08]
  // With run clear nothing ticks, so the level stays where it was. [R14]
  assign out_d = ~tick      ? out_q :
                 force_high ? 1'b1 :
                 force_low  ? 1'b0 :
                 underflow  ? 1'b1 :
                 match      ? 1'b0 :
                              out_q;

  // Bus answer takes one wait state so that every output comes from a flop.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= access;
      pslverr_q <= access & ~mapped;
      if (req.rd) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Holding registers take software writes only. [R12] [R13]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_q.period  <= PERIOD_RST;
      hold_q.compare <= COMPARE_RST;
    end else if (req.wr) begin
      if (hit_pl) hold_q.period[7:0] <= req.wdata[7:0];
      if (hit_ph) hold_q.period[CNT_W-1:8] <= req.wdata[HIGH_BYTE_W-1:0];
      if (hit_cl) hold_q.compare[7:0] <= req.wdata[7:0];
      if (hit_ch) hold_q.compare[CNT_W-1:8] <= req.wdata[HIGH_BYTE_W-1:0];
    end
  end

  // Active pair changes only at an underflow with load pending. [R16]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active_q.period  <= PERIOD_RST;
      active_q.compare <= COMPARE_RST;
    end else if (underflow & load_q) begin
      active_q <= hold_q;
    end
  end

  // A software write of load wins over the hardware clear in the same cycle. [R16]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q             <= 1'b0;
      load_q            <= 1'b0;
      prescale_select_q <= SEL_RST;
    end else begin
      if (req.wr & hit_ctl) begin
        run_q  <= req.wdata[BIT_RUN];
        load_q <= req.wdata[BIT_LOAD] | (load_q & ~underflow);
      end else if (underflow) begin
        load_q <= 1'b0;
      end
      if (req.wr & hit_ctl3) begin
        prescale_select_q <= req.wdata[SEL_W-1:0];
      end
    end
  end

  // Sticky flag: an underflow in the clearing cycle still sets it. [R17]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      counter_underflow_flag_q <= 1'b0;
      mask_q                   <= 1'b0;
      irq_q                    <= 1'b0;
    end else begin
      counter_underflow_flag_q <= underflow | (counter_underflow_flag_q &
                                  ~(req.wr & hit_sts & req.wdata[BIT_UNDERFLOW]));
      if (req.wr & hit_msk) begin
        mask_q <= req.wdata[BIT_UNDERFLOW];
      end
      irq_q <= counter_underflow_flag_q & mask_q;
    end
  end

  // Prescaler restarts whenever run is clear so the first tick is a full one. [R03]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      presc_q <= '0;
    end else if (~run_q | tick) begin
      presc_q <= '0;
    end else begin
      presc_q <= PRESC_W'(presc_q + PRESC_ONE);
    end
  end

  // Output starts high so the pin idles high once the port latch is set. [R01] [R02]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= CNT_ZERO;
      out_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign modulator_channel_zero = out_q;
  assign period_irq             = irq_q;

  // Assertions.
  a_reset_out_high: assert property (@(posedge clk) // [R01]
    $fell(sys_rst) |-> modulator_channel_zero)
    else $error("Output not high after reset.");

  a_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
    (tick & (prescale_select_q == 2'h3) & $stable(prescale_select_q)) |=>
    (!tick || (prescale_select_q != 2'h3))[*7])
    else $error("Prescale divide by eight broken.");

  a_reload_period: assert property (@(posedge clk) disable iff (sys_rst) // [R05]
    underflow |=> (cnt_q == $past(active_q.period)))
    else $error("Counter not reloaded at underflow.");

  a_count_down: assert property (@(posedge clk) disable iff (sys_rst) // [R03]
    (tick & !underflow) |=> (cnt_q == $past(cnt_q) - 10'h001))
    else $error("Counter did not step down.");

  a_high_at_uf: assert property (@(posedge clk) disable iff (sys_rst) // [R07]
    (underflow & !force_low) |=> modulator_channel_zero)
    else $error("Output not high after underflow.");

  a_low_at_match: assert property (@(posedge clk) disable iff (sys_rst) // [R08]
    (match & !underflow & !force_high) |=> !modulator_channel_zero)
    else $error("Output not low after compare match.");

  a_zero_high: assert property (@(posedge clk) disable iff (sys_rst) // [R09]
    (tick & (active_q.compare == 10'h000)) |=> modulator_channel_zero)
    else $error("Compare zero did not hold high.");

  a_ones_low: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    (tick & (active_q.compare == 10'h3FF)) |=> !modulator_channel_zero)
    else $error("Compare all ones did not hold low.");

  a_above_low: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    (tick & (active_q.compare > active_q.period)) |=> !modulator_channel_zero)
    else $error("Compare above period did not hold low.");

  a_freeze_stop: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
    (!run_q && !$past(run_q)) |-> ($stable(modulator_channel_zero) && $stable(cnt_q)))
    else $error("Output moved while stopped.");

  a_load_copy: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
    (underflow & load_q & !(req.wr & hit_ctl)) |=> (active_q == $past(hold_q)) && !load_q)
    else $error("Load did not copy and clear.");

  a_hold_only: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    !(underflow & load_q) |=> $stable(active_q))
    else $error("Active pair changed without load.");

  a_flag_set: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    underflow |=> counter_underflow_flag_q ##1 (period_irq == $past(mask_q)))
    else $error("Underflow flag or interrupt missing.");

  a_cnt_at_tick: assert property (@(posedge clk) disable iff (sys_rst) // [R03]
    !tick |=> $stable(cnt_q))
    else $error("Counter moved without a tick.");

  a_out_at_tick: assert property (@(posedge clk) disable iff (sys_rst) // [R07]
    !tick |=> $stable(modulator_channel_zero))
    else $error("Output moved without a tick.");

  a_stop_no_tick: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
    !run_q |-> !tick)
    else $error("Counter ticked while stopped.");

  a_sel_write: assert property (@(posedge clk) disable iff (sys_rst) // [R04]
    (req.wr & hit_ctl3) |=> (prescale_select_q == SEL_W'($past(pwdata))))
    else $error("Prescale select not written.");

  a_hold_period: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    (req.wr & hit_pl) |=> (hold_q.period[7:0] == 8'($past(pwdata))))
    else $error("Period low byte not held.");

  a_hold_compare: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    (req.wr & hit_cl) |=> (hold_q.compare[7:0] == 8'($past(pwdata))))
    else $error("Compare low byte not held.");

  a_load_set: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
    (req.wr & hit_ctl & pwdata[BIT_LOAD]) |=> load_q)
    else $error("Load request not taken.");

  a_load_stays: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
    (load_q & !underflow) |=> load_q)
    else $error("Load dropped before underflow.");

  a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    (counter_underflow_flag_q & !(req.wr & hit_sts & pwdata[BIT_UNDERFLOW])) |=>
    counter_underflow_flag_q)
    else $error("Underflow flag dropped by itself.");

  a_flag_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    (req.wr & hit_sts & pwdata[BIT_UNDERFLOW] & !underflow) |=> !counter_underflow_flag_q)
    else $error("Underflow flag not cleared.");

  a_irq_on: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    (counter_underflow_flag_q & mask_q) |=> period_irq)
    else $error("Interrupt missing for unmasked flag.");

  a_irq_off: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    !(counter_underflow_flag_q & mask_q) |=> !period_irq)
    else $error("Interrupt raised without unmasked flag.");

endmodule

// *** sim/port_pin_model.sv ***
/*
  Behavioural model of the shared port pin that carries the modulator output.
  Assumes the bench drives the port latch bit and watches the pin level.
*/
`timescale 1ns/1ps
module port_pin_model (
  // From the modulator and the port latch
  input  wire logic modulator_channel_zero,
  input  wire logic port_latch,
  // Pad level
  output logic      pin
);
  // A low latch sinks the pad hard; a high latch lets the pad follow the modulator output.
  // The pad is always driven by the AND of latch and modulator output, so it never floats.
  assign pin = port_latch & modulator_channel_zero;
endmodule

// *** sim/single_channel_pulse_width_modulator_test.sv ***
/*
  Self-checking testbench for the pulse width modulator channel.
  Assumes pwm_pkg, pwm_channel and port_pin_model are compiled first.
*/
`timescale 1ns/1ps
module single_channel_pulse_width_modulator_test
  import pwm_pkg::*;
();
  logic        clk = 1'b0;
  logic        sys_rst, psel, penable, pwrite, port_latch;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, saved;
  logic        pready, pslverr, modulator_channel_zero, period_irq, pin, e;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          hi, per;
  logic [9:0]  codes [3] = '{10'h3FF, 10'h005, 10'h000};

  pwm_channel u_pwm_channel (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modulator_channel_zero(modulator_channel_zero),
    .period_irq(period_irq));
  port_pin_model u_port_pin_model (.modulator_channel_zero(modulator_channel_zero),
    .port_latch(port_latch), .pin(pin));

  always #2 clk = ~clk;

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // The ceiling is more than twenty times the expected run, so only a hang reaches it.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin n++; @(posedge clk); end
    if (n == 20) chk(32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wait_load;
    int k;
    k = 0;
    do begin apb(1'b0, OFS_CONTROL, 32'h0); k++; end while (r[BIT_LOAD] !== 1'b0 && k < 100);
    chk(32'(r[BIT_LOAD]), 32'h0);
  endtask

  task automatic hold_chk(input logic lvl, input int n);
    int bad;
    bad = 0;
    repeat (n) begin @(posedge clk); if (modulator_channel_zero !== lvl) bad++; end
    chk(32'(bad), 32'h0);
  endtask

  // Edge counts are in system clocks, so one tick lasts 2^sel of them.
  task automatic meas(output int h, output int p);
    int k;
    h = 0; k = 0;
    while (modulator_channel_zero !== 1'b0 && k < 300) begin k++; @(posedge clk); end
    while (modulator_channel_zero !== 1'b1 && k < 300) begin k++; @(posedge clk); end
    while (modulator_channel_zero === 1'b1 && k < 300) begin k++; h++; @(posedge clk); end
    p = h;
    while (modulator_channel_zero === 1'b0 && k < 300) begin k++; p++; @(posedge clk); end
  endtask

  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; port_latch = 1'b0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(32'(modulator_channel_zero), 32'h1);
    chk(32'(pin), 32'h0);
    port_latch <= 1'b1;
    apb(1'b0, OFS_STATE, 32'h0);
    chk(32'(r[BIT_STATE_OUT]), 32'h1);
    chk(32'(pin), 32'h1);
    apb(1'b0, 8'h24, 32'h0);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, OFS_PERIOD_LOW, 32'h3);
    apb(1'b1, OFS_PERIOD_HIGH, 32'h0);
    apb(1'b1, OFS_COMPARE_LOW, 32'h2);
    apb(1'b1, OFS_COMPARE_HIGH, 32'h0);
    apb(1'b0, OFS_COMPARE_LOW, 32'h0);
    chk(r, 32'h2);
    apb(1'b1, OFS_CONTROL, 32'h1);
    hold_chk(1'b1, 30);
    apb(1'b1, OFS_CONTROL, 32'h3);
    wait_load;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(r[BIT_UNDERFLOW]), 32'h1);
    chk(32'(period_irq), 32'h0);
    apb(1'b1, OFS_MASK, 32'h1);
    apb(1'b0, OFS_MASK, 32'h0);
    chk(r, 32'h1);
    chk(32'(period_irq), 32'h1);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_CONTROL_3, 32'(s));
      meas(hi, per);
      meas(hi, per);
      chk(32'(hi), 32'(2 << s));
      chk(32'(per), 32'(4 << s));
    end
    apb(1'b1, OFS_CONTROL, 32'h0);
    apb(1'b0, OFS_STATE, 32'h0);
    saved = r;
    hold_chk(saved[BIT_STATE_OUT], 20);
    apb(1'b0, OFS_STATE, 32'h0);
    chk(r, saved);
    apb(1'b1, OFS_CONTROL_3, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_COMPARE_LOW, 32'(codes[i][7:0]));
      apb(1'b1, OFS_COMPARE_HIGH, 32'(codes[i][9:8]));
      apb(1'b1, OFS_CONTROL, 32'h3);
      wait_load;
      hold_chk(codes[i] == 10'h000, 40);
    end
    apb(1'b1, OFS_CONTROL, 32'h0);
    apb(1'b0, OFS_STATE, 32'h0);
    saved = r;
    hold_chk(1'b1, 20);
    apb(1'b0, OFS_STATE, 32'h0);
    chk(r, saved);
    apb(1'b1, OFS_STATUS, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(r[BIT_UNDERFLOW]), 32'h0);
    chk(32'(period_irq), 32'h0);
    port_latch <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(pin), 32'h0);
    give_verdict;
  end
endmodule
